// ==== hdl/dstq_pkg.sv ====
// dstq_pkg: register map, field layout, reset values and timing counts for the
// display swap and tag query block.
// assumes: a single 100 MHz system clock; offsets are byte addresses.
package dstq_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COORD_W = 11;
  localparam int unsigned TAG_W = 8;
  localparam int unsigned LINE_W = 12;
  localparam int unsigned SWAP_W = 2;

  // register offsets
  localparam logic [7:0] OFF_LINE_PERIOD = 8'h2c;
  localparam logic [7:0] OFF_SWAP_CTRL = 8'h54;
  localparam logic [7:0] OFF_QUERY_X = 8'h74;
  localparam logic [7:0] OFF_QUERY_Y = 8'h78;
  localparam logic [7:0] OFF_TAG_RESULT = 8'h7c;
  // own status register: bit 0 = frame end seen, bits 27:16 = current pixel
  localparam logic [7:0] OFF_SCAN_STATUS = 8'h90;

  // reset values
  localparam logic [11:0] LINE_PERIOD_RST = 12'h0224;
  localparam logic [11:0] LINES_PER_FRAME_RST = 12'h0124;
  localparam logic [1:0] SWAP_RST = 2'h0;
  localparam logic [10:0] COORD_RST = 11'h000;
  localparam logic [7:0] TAG_RST = 8'h00;

  // swap codes
  localparam logic [1:0] SWAP_LINE = 2'h1;
  localparam logic [1:0] SWAP_FRAME = 2'h2;

  // pixel clock: 100 MHz system clock divided down to a pixel enable
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned PIX_CLK_MHZ = 25;
  localparam int unsigned PIX_DIV = SYS_CLK_MHZ / PIX_CLK_MHZ;
  localparam logic [3:0] PIX_DIV_LAST = 4'(PIX_DIV - 1);

  typedef enum logic [1:0] {
    DSTQ_SW_IDLE,
    DSTQ_SW_WAIT_LINE,
    DSTQ_SW_WAIT_FRAME
  } dstq_swap_st_t;

endpackage : dstq_pkg

// ==== hdl/dstq_tag_store.sv ====
// dstq_tag_store: per-pixel tag memory of the last rendered frame, indexed by
// an x/y coordinate; writes come from the renderer, reads from the query logic.
// assumes: renderer writes frontmost tag only (later writes overwrite earlier).
`timescale 1ns/1ps
module dstq_tag_store
  import dstq_pkg::*;
#(
  parameter int unsigned X_BITS = 5,
  parameter int unsigned Y_BITS = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [dstq_pkg::COORD_W-1:0] wr_x,
  input wire logic [dstq_pkg::COORD_W-1:0] wr_y,
  input wire logic [dstq_pkg::TAG_W-1:0] wr_tag,
  input wire logic [dstq_pkg::COORD_W-1:0] rd_x,
  input wire logic [dstq_pkg::COORD_W-1:0] rd_y,
  output logic [dstq_pkg::TAG_W-1:0] rd_tag
);

  logic [TAG_W-1:0] mem [0:(1<<(X_BITS+Y_BITS))-1];

  function automatic logic [X_BITS+Y_BITS-1:0] idx(input logic [COORD_W-1:0] x,
                                                   input logic [COORD_W-1:0] y);
    idx = {y[Y_BITS-1:0], x[X_BITS-1:0]};
  endfunction : idx

  function automatic logic in_range(input logic [COORD_W-1:0] x,
                                    input logic [COORD_W-1:0] y);
    in_range = ((x >> X_BITS) == '0) && ((y >> Y_BITS) == '0);
  endfunction : in_range

  always_ff @(posedge core_clk) begin
    if (wr_en && in_range(wr_x, wr_y)) begin
      mem[idx(wr_x, wr_y)] <= wr_tag;
    end
  end

  // a pixel reads zero until the renderer has tagged it since reset
  localparam int unsigned DEPTH = 1 << (X_BITS + Y_BITS);
  logic [DEPTH-1:0] valid_r, valid_nxt;

  always_comb begin
    valid_nxt = valid_r;
    if (wr_en && in_range(wr_x, wr_y)) begin
      valid_nxt[idx(wr_x, wr_y)] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      valid_r <= '0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // outside the stored area nothing is drawn, so no tag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_tag <= '0;
    end else if (in_range(rd_x, rd_y) && valid_r[idx(rd_x, rd_y)]) begin
      rd_tag <= mem[idx(rd_x, rd_y)];
    end else begin
      rd_tag <= '0;
    end
  end

endmodule : dstq_tag_store

// ==== hdl/dstq_top.sv ====
// dstq_top: line period, display list swap control and tag query registers.
// assumes: synchronous register port, one-cycle strobes, read data next cycle;
// the renderer delivers tags through the tag_wr port and a list swap pulse out.
`timescale 1ns/1ps
module dstq_top
  import dstq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [dstq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dstq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dstq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [dstq_pkg::LINE_W-1:0] lines_per_frame,
  input wire logic tag_wr_en,
  input wire logic [dstq_pkg::COORD_W-1:0] tag_wr_x,
  input wire logic [dstq_pkg::COORD_W-1:0] tag_wr_y,
  input wire logic [dstq_pkg::TAG_W-1:0] tag_wr_tag,
  output logic pix_en,
  output logic line_end,
  output logic frame_end,
  output logic list_swap
);
  import dstq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [LINE_W-1:0] line_period_r, line_period_nxt;
  logic [SWAP_W-1:0] swap_code_r, swap_code_nxt;
  logic [COORD_W-1:0] query_x_r, query_x_nxt;
  logic [COORD_W-1:0] query_y_r, query_y_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic frame_seen_r, frame_seen_nxt;
  dstq_swap_st_t swap_st_r, swap_st_nxt;
  logic [TAG_W-1:0] tag_result;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // step at counter width, so a compare with the period stays 12 bits and
  // a full counter wraps rather than widening
  function automatic logic [LINE_W-1:0] step(input logic [LINE_W-1:0] v);
    step = v + 12'h001;
  endfunction : step

  // write strobe aimed at one register offset
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off);
    wr_hit = wr && (a == off);
  endfunction : wr_hit

  // narrow field in the low bits of a bus word, reserved bits read zero
  function automatic logic [DATA_W-1:0] low_field(input logic [LINE_W-1:0] v);
    low_field = {20'h0_0000, v};
  endfunction : low_field

  ////////////////////////////////////////////////////////////////////////////
  // pixel enable and scan position

  logic [3:0] div_r, div_nxt;
  logic [LINE_W-1:0] pix_r, pix_nxt;
  logic [LINE_W-1:0] line_r, line_nxt;
  logic pix_en_r, pix_en_nxt;
  logic line_end_r, line_end_nxt;
  logic frame_end_r, frame_end_nxt;
  logic [LINE_W-1:0] frame_lines;

  // zero lines would end a frame at every line, as one does, so treat it as one
  assign frame_lines = (lines_per_frame == '0) ? 12'h0001 : lines_per_frame;

  always_comb begin
    div_nxt = div_r;
    pix_nxt = pix_r;
    line_nxt = line_r;
    pix_en_nxt = 1'b0;
    line_end_nxt = 1'b0;
    frame_end_nxt = 1'b0;
    if (div_r == PIX_DIV_LAST) begin
      div_nxt = '0;
      pix_en_nxt = 1'b1;
    end else begin
      div_nxt = div_r + 4'h1;
    end
    if (pix_en_r) begin
      // line length follows the period register; shrinking it mid-line to pix_r + 1 or less ends the line at the next pixel enable
      if (step(pix_r) >= line_period_r) begin
        pix_nxt = '0;
        line_end_nxt = 1'b1;
        if (step(line_r) >= frame_lines) begin
          line_nxt = '0;
          frame_end_nxt = 1'b1;
        end else begin
          line_nxt = step(line_r);
        end
      end else begin
        pix_nxt = step(pix_r);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r <= '0;
      pix_r <= '0;
      line_r <= '0;
      pix_en_r <= 1'b0;
      line_end_r <= 1'b0;
      frame_end_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      pix_r <= pix_nxt;
      line_r <= line_nxt;
      pix_en_r <= pix_en_nxt;
      line_end_r <= line_end_nxt;
      frame_end_r <= frame_end_nxt;
    end
  end

  assign pix_en = pix_en_r;
  assign line_end = line_end_r;
  assign frame_end = frame_end_r;

  ////////////////////////////////////////////////////////////////////////////
  // swap sequencer

  logic swap_fire;
  logic swap_wr, swap_req_line, swap_req_frame;

  // only the two legal codes start a swap; 00 and 11 leave the field unchanged
  assign swap_wr = wr_hit(reg_wr, reg_addr, OFF_SWAP_CTRL);
  assign swap_req_line = swap_wr && (reg_wdata[SWAP_W-1:0] == SWAP_LINE);
  assign swap_req_frame = swap_wr && (reg_wdata[SWAP_W-1:0] == SWAP_FRAME);

  always_comb begin
    swap_st_nxt = swap_st_r;
    swap_fire = 1'b0;
    case (swap_st_r)
      DSTQ_SW_IDLE: begin
        if (swap_req_line) begin
          swap_st_nxt = DSTQ_SW_WAIT_LINE;
        end else if (swap_req_frame) begin
          swap_st_nxt = DSTQ_SW_WAIT_FRAME;
        end
      end
      DSTQ_SW_WAIT_LINE: begin
        if (line_end_r) begin
          swap_fire = 1'b1;
          swap_st_nxt = DSTQ_SW_IDLE;
        end
      end
      DSTQ_SW_WAIT_FRAME: begin
        if (frame_end_r) begin
          swap_fire = 1'b1;
          swap_st_nxt = DSTQ_SW_IDLE;
        end
      end
      default: begin
        swap_st_nxt = DSTQ_SW_IDLE;
      end
    endcase
  end

  // the field mirrors the pending code; writes while pending are dropped
  always_comb begin
    swap_code_nxt = swap_code_r;
    if (swap_fire) begin
      swap_code_nxt = SWAP_RST;
    end else if (swap_st_r == DSTQ_SW_IDLE && swap_st_nxt == DSTQ_SW_WAIT_LINE) begin
      swap_code_nxt = SWAP_LINE;
    end else if (swap_st_r == DSTQ_SW_IDLE && swap_st_nxt == DSTQ_SW_WAIT_FRAME) begin
      swap_code_nxt = SWAP_FRAME;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      swap_st_r <= DSTQ_SW_IDLE;
      swap_code_r <= SWAP_RST;
    end else begin
      swap_st_r <= swap_st_nxt;
      swap_code_r <= swap_code_nxt;
    end
  end

  // registered pulse the renderer uses to flip display lists
  logic list_swap_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      list_swap_r <= 1'b0;
    end else begin
      list_swap_r <= swap_fire;
    end
  end

  assign list_swap = list_swap_r;

  ////////////////////////////////////////////////////////////////////////////
  // writable registers and sticky frame flag

  always_comb begin
    line_period_nxt = line_period_r;
    query_x_nxt = query_x_r;
    query_y_nxt = query_y_r;
    frame_seen_nxt = frame_seen_r;
    if (reg_wr) begin
      if (reg_addr == OFF_LINE_PERIOD) begin
        line_period_nxt = reg_wdata[LINE_W-1:0];
      end else if (reg_addr == OFF_QUERY_X) begin
        query_x_nxt = reg_wdata[COORD_W-1:0];
      end else if (reg_addr == OFF_QUERY_Y) begin
        query_y_nxt = reg_wdata[COORD_W-1:0];
      end
    end
    if (wr_hit(reg_wr, reg_addr, OFF_SCAN_STATUS) && reg_wdata[0]) begin
      frame_seen_nxt = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (frame_end_r) begin
      frame_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_period_r <= LINE_PERIOD_RST;
      query_x_r <= COORD_RST;
      query_y_r <= COORD_RST;
      frame_seen_r <= 1'b0;
    end else begin
      line_period_r <= line_period_nxt;
      query_x_r <= query_x_nxt;
      query_y_r <= query_y_nxt;
      frame_seen_r <= frame_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tag lookup: only the software coordinates address store reads; renderer tag_wr coordinates address writes

  dstq_tag_store u_tag_store (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(tag_wr_en),
    .wr_x(tag_wr_x),
    .wr_y(tag_wr_y),
    .wr_tag(tag_wr_tag),
    .rd_x(query_x_r),
    .rd_y(query_y_r),
    .rd_tag(tag_result)
  );
  // store holds the frontmost tag per pixel, zero where nothing tagged

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      if (reg_addr == OFF_LINE_PERIOD) begin
        rdata_nxt = low_field(line_period_r);
      end else if (reg_addr == OFF_SWAP_CTRL) begin
        rdata_nxt = low_field({10'h000, swap_code_r});
      end else if (reg_addr == OFF_QUERY_X) begin
        rdata_nxt = low_field({1'b0, query_x_r});
      end else if (reg_addr == OFF_QUERY_Y) begin
        rdata_nxt = low_field({1'b0, query_y_r});
      end else if (reg_addr == OFF_TAG_RESULT) begin
        rdata_nxt = low_field({4'h0, tag_result});
      end else if (reg_addr == OFF_SCAN_STATUS) begin
        rdata_nxt = {4'h0, pix_r, 15'h0000, frame_seen_r};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : dstq_top

// ==== bench/dstq_chk_sva.sv ====
// dstq_chk_sva: port-level checks of the scan timing, swap and query registers.
// assumes: bound to dstq_top; read data stand in the cycle after the strobe.
`timescale 1ns/1ps
module dstq_chk
  import dstq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [dstq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dstq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dstq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pix_en,
  input wire logic line_end,
  input wire logic frame_end,
  input wire logic list_swap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // pixel count per line; two line ends are skipped after a period write,
  // since a line cut short by the write has no defined length
  logic [11:0] per_r, per_nxt, cnt_r, cnt_nxt;
  logic [1:0] ok_r, ok_nxt;
  always_comb begin
    per_nxt = per_r;
    ok_nxt = ok_r;
    cnt_nxt = line_end ? 12'h000 : cnt_r + 12'(pix_en);
    if (line_end && ok_r != 2'h2) ok_nxt = ok_r + 2'h1;
    if (reg_wr && reg_addr == OFF_LINE_PERIOD) begin
      per_nxt = reg_wdata[11:0];
      ok_nxt = 2'h0;
    end
  end
  // pending swap code as software asked for it; illegal codes and writes
  // while a swap is pending are dropped
  logic [1:0] pend_r, pend_nxt;
  always_comb begin
    pend_nxt = pend_r;
    if ((pend_r == SWAP_LINE && line_end) || (pend_r == SWAP_FRAME && frame_end)) begin
      pend_nxt = 2'h0;
    end else if (pend_r == 2'h0 && reg_wr && reg_addr == OFF_SWAP_CTRL
                 && (reg_wdata[1:0] == SWAP_LINE || reg_wdata[1:0] == SWAP_FRAME)) begin
      pend_nxt = reg_wdata[1:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      per_r <= LINE_PERIOD_RST;
      pend_r <= 2'h0;
      ok_r <= 2'h0;
      cnt_r <= 12'h000;
    end else begin
      per_r <= per_nxt;
      pend_r <= pend_nxt;
      ok_r <= ok_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  ////////////////////////////////////////
  per_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_LINE_PERIOD
    |-> reg_rdata[31:12] == '0) else $error("line period reserved bits set");
  line_len_a: assert property (line_end && ok_r == 2'h2
    |-> cnt_r + 12'(pix_en) == per_r) else $error("line length differs from period");
  pix_rate_a: assert property (pix_en |=> !pix_en [*3] ##1 pix_en)
    else $error("pixel enable spacing wrong");
  line_swap_a: assert property (list_swap |-> $past(line_end))
    else $error("swap without line end");
  frame_line_a: assert property (frame_end |-> line_end)
    else $error("frame end without line end");
  swap_code_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_SWAP_CTRL
    |-> reg_rdata[31:2] == '0 && reg_rdata[1:0] != 2'h3) else $error("swap field bad");
  tag_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_TAG_RESULT
    |-> reg_rdata[31:8] == '0) else $error("tag reserved bits set");
  qy_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_QUERY_Y
    |-> reg_rdata[31:11] == '0) else $error("query y reserved bits set");
  qx_bits_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_QUERY_X
    |-> reg_rdata[31:11] == '0) else $error("query x reserved bits set");
  line_due_a: assert property (pend_r == SWAP_LINE && line_end |=> list_swap)
    else $error("line swap missed");
  frame_due_a: assert property (pend_r == SWAP_FRAME && frame_end |=> list_swap)
    else $error("frame swap missed");
  frame_wait_a: assert property (pend_r == SWAP_FRAME && !frame_end |=> !list_swap)
    else $error("frame swap too early");
  swap_read_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_SWAP_CTRL
    |-> reg_rdata[1:0] == $past(pend_r)) else $error("swap field not pending code");
endmodule : dstq_chk
bind dstq_top dstq_chk chk_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pix_en, .line_end, .frame_end, .list_swap);

// ==== bench/tb.sv ====
// tb: self-checking bench for dstq_top through its register port and scan pulses.
// assumes: 100 MHz core_clk; the bench plays the renderer on the tag write port.
`timescale 1ns/1ps
module tb;
  import dstq_pkg::*;
  localparam logic [31:0] Z = 32'h0000_0000;
  localparam logic [31:0] O1 = 32'h0000_0001;
  logic core_clk, rst, reg_wr, reg_rd, tag_wr_en, pix_en, line_end, frame_end, list_swap;
  logic [7:0] reg_addr, tag_wr_tag;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [11:0] lines_per_frame;
  logic [10:0] tag_wr_x, tag_wr_y;
  int bad_count = 0;
  int comparisons = 0;
  dstq_top dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lines_per_frame, .tag_wr_en, .tag_wr_x, .tag_wr_y, .tag_wr_tag, .pix_en, .line_end,
    .frame_end, .list_swap);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, d, e);
  endtask : rc
  task automatic tw(input logic [10:0] x, input logic [10:0] y, input logic [7:0] t);
    @(posedge core_clk);
    tag_wr_en <= 1'b1;
    tag_wr_x <= x;
    tag_wr_y <= y;
    tag_wr_tag <= t;
    @(posedge core_clk);
    tag_wr_en <= 1'b0;
  endtask : tw
  // k: 0 plain line end, 1 frame end, 2 any line end; returns in the following cycle
  task automatic wait_end(input logic [1:0] k);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge core_clk);
      #1;
      if (line_end === 1'b1 && (k == 2'h2 || frame_end === k[0])) break;
    end
    if (i == 20000) begin
      bad_count++;
      $display("CHECK FAILED scan end expected pulse seen none");
      conclude();
    end else begin
      @(posedge core_clk);
      #1;
    end
  endtask : wait_end
  ////////////////////////////////////////
  task automatic t_reset();
    rc("line period", OFF_LINE_PERIOD, 32'h0000_0224);
    rc("swap", OFF_SWAP_CTRL, Z);
    rc("query x", OFF_QUERY_X, Z);
    rc("query y", OFF_QUERY_Y, Z);
    rc("tag", OFF_TAG_RESULT, Z);
    rc("unmapped", 8'h10, Z);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    wr(OFF_LINE_PERIOD, 32'hFFFF_F008);
    rc("line period", OFF_LINE_PERIOD, 32'h0000_0008);
    wr(OFF_QUERY_X, 32'hFFFF_FFFF);
    rc("query x", OFF_QUERY_X, 32'h0000_07FF);
    wr(OFF_QUERY_Y, 32'h0000_0C05);
    rc("query y", OFF_QUERY_Y, 32'h0000_0405);
    wr(OFF_TAG_RESULT, 32'h0000_00FF);
    rc("tag read only", OFF_TAG_RESULT, Z);
    $display("test regs done");
  endtask : t_regs
  task automatic t_swap_line();
    wr(OFF_SWAP_CTRL, 32'h0000_0003);
    rc("swap code 11", OFF_SWAP_CTRL, Z);
    wr(OFF_SWAP_CTRL, Z);
    rc("swap code 00", OFF_SWAP_CTRL, Z);
    wait_end(2'h2);
    wr(OFF_SWAP_CTRL, O1);
    rc("line swap pending", OFF_SWAP_CTRL, O1);
    wait_end(2'h2);
    chk("line swap pulse", 32'(list_swap), O1);
    rc("line swap done", OFF_SWAP_CTRL, Z);
    $display("test line swap done");
  endtask : t_swap_line
  task automatic t_swap_frame();
    wait_end(2'h1);
    wr(OFF_SWAP_CTRL, 32'h0000_0002);
    wait_end(2'h0);
    chk("no swap at line", 32'(list_swap), Z);
    rc("frame swap pending", OFF_SWAP_CTRL, 32'h0000_0002);
    wr(OFF_SWAP_CTRL, O1);
    rc("write while pending", OFF_SWAP_CTRL, 32'h0000_0002);
    wait_end(2'h1);
    chk("frame swap pulse", 32'(list_swap), O1);
    rc("frame swap done", OFF_SWAP_CTRL, Z);
    $display("test frame swap done");
  endtask : t_swap_frame
  task automatic t_tag();
    tw(11'h003, 11'h004, 8'h5A);
    tw(11'h003, 11'h004, 8'hA5);
    tw(11'h01F, 11'h000, 8'h11);
    wr(OFF_QUERY_X, 32'h0000_0003);
    wr(OFF_QUERY_Y, 32'h0000_0004);
    rc("front tag", OFF_TAG_RESULT, 32'h0000_00A5);
    wr(OFF_QUERY_X, 32'h0000_001F);
    wr(OFF_QUERY_Y, Z);
    rc("edge tag", OFF_TAG_RESULT, 32'h0000_0011);
    wr(OFF_QUERY_X, 32'h0000_0005);
    wr(OFF_QUERY_Y, 32'h0000_0005);
    rc("empty tag", OFF_TAG_RESULT, Z);
    $display("test tag done");
  endtask : t_tag
  task automatic t_status();
    rd(OFF_SCAN_STATUS);
    chk("frame seen", 32'(d[0]), O1);
    chk("pixel below period", 32'(d[27:16] < 12'h008), O1);
    wr(OFF_SCAN_STATUS, O1);
    rd(OFF_SCAN_STATUS);
    chk("frame seen cleared", 32'(d[0]), Z);
    wait_end(2'h1);
    rd(OFF_SCAN_STATUS);
    chk("frame seen again", 32'(d[0]), O1);
    $display("test status done");
  endtask : t_status
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = Z;
    tag_wr_en = 1'b0;
    tag_wr_x = 11'h000;
    tag_wr_y = 11'h000;
    tag_wr_tag = 8'h00;
    lines_per_frame = 12'h003;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_swap_line();
    t_swap_frame();
    t_status();
    t_tag();
    conclude();
  end
endmodule : tb
